// ### design/lej_defs.svh
// register offsets, field positions, reset values and timing counts
`ifndef LEJ_DEFS_SVH
`define LEJ_DEFS_SVH

// register indices; byte address is four times the index
`define LEJ_IDX_IRQ_STATUS  11'h022
`define LEJ_IDX_ERR_LOW     11'h023
`define LEJ_IDX_ERR_HIGH    11'h024
`define LEJ_CH_STRIDE       11'h040
`define LEJ_IDX_CH0_ERR_LOW 11'h7E3
`define LEJ_IDX_CH0_ERR_HI  11'h7E4
`define LEJ_IDX_JM_CONFIG   11'h7E5
`define LEJ_IDX_POS_LOW     11'h7E6
`define LEJ_IDX_POS_HIGH    11'h7E7
`define LEJ_IDX_NEG_LOW     11'h7E8
`define LEJ_IDX_NEG_HIGH    11'h7E9
`define LEJ_IDX_ERR_CTRL    11'h7F0

// line_event_irq_status fields
`define LEJ_BIT_SBPV  5
`define LEJ_BIT_LBPV  4
`define LEJ_BIT_SEXZ  3
`define LEJ_BIT_LEXZ  2
`define LEJ_BIT_PAT   1
`define LEJ_BIT_CNTOV 0

// jitter_meas_config fields
`define LEJ_BIT_JITTER_MANUAL_STOP 2
`define LEJ_BIT_JITTER_PERIOD_SELECT   1
`define LEJ_BIT_JITTER_FILTER_BAND   0

// error control fields
`define LEJ_BIT_CNT_SEL 0
`define LEJ_BIT_CNT_UPD 1

// reset values
`define LEJ_RST_IRQ    8'h00
`define LEJ_RST_ERROR_COUNT_VALUE   16'h0000
`define LEJ_RST_JM     3'h0
`define LEJ_RST_PEAK   12'h000
`define LEJ_RST_CTRL   1'h0

// timing
`define LEJ_CLK_NS     100
`define LEJ_PERIOD_NS  1000000000
`define LEJ_PERIOD_CYC (`LEJ_PERIOD_NS / `LEJ_CLK_NS)

`endif

// ### design/lej_pkg.sv
// types shared by the line error and jitter status register block
`default_nettype none
package lej_pkg;

    // one channel's event pulses from the detectors
    typedef struct packed {
        logic sbpv;
        logic lbpv;
        logic sexz;
        logic lexz;
        logic pat_err;
        logic cnt_err;
    } lej_evt_t;

    typedef enum {
        LEJ_SEL_NONE,
        LEJ_SEL_IRQ,
        LEJ_SEL_ERRL,
        LEJ_SEL_ERRH,
        LEJ_SEL_JM,
        LEJ_SEL_PPL,
        LEJ_SEL_PPH,
        LEJ_SEL_NPL,
        LEJ_SEL_NPH,
        LEJ_SEL_CTRL
    } lej_sel_t;

    typedef struct packed {
        lej_sel_t   sel;
        logic [3:0] ch;
    } lej_dec_t;

    typedef struct packed {
        logic [11:0] pos;
        logic [11:0] neg;
    } lej_peak_t;

endpackage : lej_pkg
`default_nettype wire

// ### design/lej_regs.sv
// line error, error counter and channel-0 jitter register bank on apb
// Behaviour
// - bit 5 flag set on system-side bipolar violation, drives irq
// - bit 4 flag set on line-side bipolar violation, drives irq
// - bit 3 flag set on system-side excess zeros, drives irq
// - bit 2 flag set on line-side excess zeros, drives irq
// - bit 1 flag set on pattern error, drives irq
// - bit 0 flag set when 16-bit error counter overflows, drives irq
// - flags reset to zero and clear when software writes one
// - error count shown as low byte and high byte registers
// - count copied to readable registers automatically or on manual request
// - both count byte registers read-only, reset to zero
// - status and count copies for channels 1-15, counts also channel 0
// - jitter config is channel 0 only, read-write, resets to zero
// - period select 0: period ends only on manual stop
// - period select 1: one-second periods run automatically
// - period select 0: stop bit rising edge loads positive and negative peak registers
// - filter band bit selects the jitter measurement band
// - peaks are 12-bit values over two registers, value/16 UIpp
////////////////////////////////////////////////////////////////////////
`include "lej_defs.svh"
`default_nettype none

module lej_regs
    import lej_pkg::*;
#(
    parameter int unsigned PERIOD_CYC = `LEJ_PERIOD_CYC
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                pce,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [15:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output var  logic [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire lej_evt_t [15:0]     line_evt,
    input  wire lej_peak_t           peak_in,
    output var  logic                jitter_filter_band,
    output var  logic                jitter_period_select,
    output logic                     irq
);

    ////////////////////////////////////////////////////////////////////
    // address decode

    function automatic lej_dec_t dec_addr(input logic [15:0] a);
        lej_dec_t   d;
        logic [10:0] idx;
        logic [10:0] off;
        d.sel = LEJ_SEL_NONE;
        d.ch  = 4'h0;
        idx   = a[12:2];
        off   = {5'h00, idx[5:0]};
        if (a[1:0] != 2'h0 || a[15:13] != 3'h0) begin
            d.sel = LEJ_SEL_NONE;
        end else if (idx == `LEJ_IDX_CH0_ERR_LOW) begin
            d.sel = LEJ_SEL_ERRL;
        end else if (idx == `LEJ_IDX_CH0_ERR_HI) begin
            d.sel = LEJ_SEL_ERRH;
        end else if (idx == `LEJ_IDX_JM_CONFIG) begin
            d.sel = LEJ_SEL_JM;
        end else if (idx == `LEJ_IDX_POS_LOW) begin
            d.sel = LEJ_SEL_PPL;
        end else if (idx == `LEJ_IDX_POS_HIGH) begin
            d.sel = LEJ_SEL_PPH;
        end else if (idx == `LEJ_IDX_NEG_LOW) begin
            d.sel = LEJ_SEL_NPL;
        end else if (idx == `LEJ_IDX_NEG_HIGH) begin
            d.sel = LEJ_SEL_NPH;
        end else if (idx == `LEJ_IDX_ERR_CTRL) begin
            d.sel = LEJ_SEL_CTRL;
        end else if (idx[10] == 1'b0 && idx[9:6] != 4'hF) begin
            // channels 1..15 sit at (n-1)*stride
            d.ch = idx[9:6] + 4'h1;
            if (off == `LEJ_IDX_IRQ_STATUS) begin
                d.sel = LEJ_SEL_IRQ;
            end else if (off == `LEJ_IDX_ERR_LOW) begin
                d.sel = LEJ_SEL_ERRL;
            end else if (off == `LEJ_IDX_ERR_HIGH) begin
                d.sel = LEJ_SEL_ERRH;
            end
        end
        return d;
    endfunction : dec_addr

    lej_dec_t dec;
    logic     wr_acc;
    logic     rd_setup;

    always_comb begin
        dec = dec_addr(paddr);
    end

    // single-wait-free slave; a frozen clock enable also stalls the bus
    assign pready   = pce;
    assign pslverr  = psel & penable & (dec.sel == LEJ_SEL_NONE);
    assign wr_acc   = pce & psel & penable & pwrite;
    assign rd_setup = pce & psel & ~penable & ~pwrite;

    ////////////////////////////////////////////////////////////////////
    // period timer shared by the counter rounds and jitter periods

    logic [31:0] sec_cnt_ff;
    logic        sec_tick;

    assign sec_tick = (sec_cnt_ff == PERIOD_CYC - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_cnt_ff <= 32'h00000000;
        end else if (pce) begin
            sec_cnt_ff <= sec_tick ? 32'h00000000 : sec_cnt_ff + 32'h00000001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // error counter control

    logic cnt_sel_ff;
    logic cnt_upd_req;
    logic cnt_upd;

    assign cnt_upd_req = wr_acc & (dec.sel == LEJ_SEL_CTRL) & pwdata[`LEJ_BIT_CNT_UPD];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_sel_ff <= `LEJ_RST_CTRL;
        end else if (wr_acc && dec.sel == LEJ_SEL_CTRL) begin
            cnt_sel_ff <= pwdata[`LEJ_BIT_CNT_SEL];
        end
    end

    assign cnt_upd = cnt_sel_ff ? cnt_upd_req : (pce & sec_tick);

    ////////////////////////////////////////////////////////////////////
    // per-channel flags and counters

    logic [7:0]  irq_flags [16];
    logic [15:0] error_count_value      [16];
    logic [15:0] irq_any;

    for (genvar g = 0; g < 16; g++) begin : g_ch
        logic [15:0] cnt_ff;
        logic [15:0] error_count_value_ff;
        logic        ovf;

        assign ovf = line_evt[g].cnt_err & (cnt_ff == 16'hFFFF);

        // accumulate and expose as two bytes
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cnt_ff  <= `LEJ_RST_ERROR_COUNT_VALUE;
                error_count_value_ff <= `LEJ_RST_ERROR_COUNT_VALUE;
            end else if (pce) begin
                if (cnt_upd) begin
                    error_count_value_ff <= cnt_ff;
                    cnt_ff  <= {15'h0000, line_evt[g].cnt_err};
                end else if (line_evt[g].cnt_err) begin
                    cnt_ff <= cnt_ff + 16'h0001;
                end
            end
        end

        assign error_count_value[g] = error_count_value_ff;

        if (g == 0) begin : g_noirq
            // channel 0 has counter bytes only
            assign irq_flags[g] = 8'h00;
        end else begin : g_irq
            logic [7:0] flags_ff;
            logic [7:0] set_v;
            logic [7:0] clr_v;

            always_comb begin
                set_v                = 8'h00;
                set_v[`LEJ_BIT_SBPV] = line_evt[g].sbpv;
                set_v[`LEJ_BIT_LBPV] = line_evt[g].lbpv;
                set_v[`LEJ_BIT_SEXZ] = line_evt[g].sexz;
                set_v[`LEJ_BIT_LEXZ] = line_evt[g].lexz;
                set_v[`LEJ_BIT_PAT]  = line_evt[g].pat_err;
                set_v[`LEJ_BIT_CNTOV] = ovf;
            end

            assign clr_v = (wr_acc && dec.sel == LEJ_SEL_IRQ && dec.ch == 4'(g))
                         ? pwdata[7:0] : 8'h00;

            // write one clears, a same-cycle event wins
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    flags_ff <= `LEJ_RST_IRQ;
                end else if (pce) begin
                    flags_ff <= (flags_ff & ~clr_v) | set_v;
                end
            end

            assign irq_flags[g] = flags_ff;
        end

        assign irq_any[g] = |irq_flags[g];
    end

    // level output while any flag is set
    assign irq = |irq_any;

    ////////////////////////////////////////////////////////////////////
    // channel-0 jitter measurement configuration

    logic [2:0] jm_ff;
    logic       stop_prev_ff;
    logic       peak_load;
    lej_peak_t  peak_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            jm_ff <= `LEJ_RST_JM;
        end else if (wr_acc && dec.sel == LEJ_SEL_JM) begin
            jm_ff <= pwdata[2:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_prev_ff <= 1'b0;
        end else if (pce) begin
            stop_prev_ff <= jm_ff[`LEJ_BIT_JITTER_MANUAL_STOP];
        end
    end

    // manual mode ends on stop rising edge; ignored in auto
    // auto mode ends every period tick
    // a held stop bit gives no further edges
    assign peak_load = jm_ff[`LEJ_BIT_JITTER_PERIOD_SELECT]
                     ? (pce & sec_tick)
                     : (pce & jm_ff[`LEJ_BIT_JITTER_MANUAL_STOP] & ~stop_prev_ff);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            peak_ff <= {`LEJ_RST_PEAK, `LEJ_RST_PEAK};
        end else if (peak_load) begin
            peak_ff <= peak_in;
        end
    end

    // band select and period select outputs, registered from the config
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            jitter_filter_band   <= 1'b0;
            jitter_period_select <= 1'b0;
        end else begin
            jitter_filter_band   <= jm_ff[`LEJ_BIT_JITTER_FILTER_BAND];
            jitter_period_select <= jm_ff[`LEJ_BIT_JITTER_PERIOD_SELECT];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data, captured in the setup phase

    logic [31:0] nxt_rd;

    always_comb begin
        nxt_rd = 32'h00000000;
        case (dec.sel)
            LEJ_SEL_IRQ:  nxt_rd[7:0] = irq_flags[dec.ch];
            LEJ_SEL_ERRL: nxt_rd[7:0] = error_count_value[dec.ch][7:0];
            LEJ_SEL_ERRH: nxt_rd[7:0] = error_count_value[dec.ch][15:8];
            LEJ_SEL_JM:   nxt_rd[2:0] = jm_ff;
            LEJ_SEL_PPL:  nxt_rd[7:0] = peak_ff.pos[7:0];
            LEJ_SEL_PPH:  nxt_rd[3:0] = peak_ff.pos[11:8];
            LEJ_SEL_NPL:  nxt_rd[7:0] = peak_ff.neg[7:0];
            LEJ_SEL_NPH:  nxt_rd[3:0] = peak_ff.neg[11:8];
            LEJ_SEL_CTRL: nxt_rd[0]   = cnt_sel_ff;
            default:      nxt_rd      = 32'h00000000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_setup) begin
            prdata <= nxt_rd;
        end
    end

endmodule : lej_regs
`default_nettype wire

// ### bench/lej_regs_assertions.sv
// concurrent checks on the register bank ports
`default_nettype none
module lej_regs_assertions
    import lej_pkg::*;
(
    input wire logic            pclk,
    input wire logic            presetn,
    input wire logic            pce,
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pwrite,
    input wire logic [15:0]     paddr,
    input wire logic [31:0]     pwdata,
    input wire lej_evt_t [15:0] line_evt,
    input wire logic            irq,
    input wire logic            jitter_filter_band,
    input wire logic            jitter_period_select
);
    logic jm_wr;
    logic any_wr;
    assign jm_wr  = psel && penable && pwrite && pce && paddr == 16'h1F94;
    assign any_wr = psel && penable && pwrite;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////
    AST_SBPV_IRQ: assert property (pce && line_evt[5].sbpv |=> irq)
        else $error("irq low after system bipolar event");
    AST_LBPV_IRQ: assert property (pce && line_evt[4].lbpv |=> irq)
        else $error("irq low after line bipolar event");
    AST_SEXZ_IRQ: assert property (pce && line_evt[3].sexz |=> irq)
        else $error("irq low after system zeros event");
    AST_LEXZ_IRQ: assert property (pce && line_evt[2].lexz |=> irq)
        else $error("irq low after line zeros event");
    AST_PAT_IRQ: assert property (pce && line_evt[1].pat_err |=> irq)
        else $error("irq low after pattern error");
    // only a register write can take the flags down
    AST_IRQ_HOLD: assert property (irq && !any_wr |=> irq)
        else $error("irq dropped without a write");
    AST_BAND_OUT: assert property (jm_wr |=> ##1 jitter_filter_band == $past(pwdata[0], 2))
        else $error("band output does not follow config");
    AST_PERIOD_OUT: assert property (jm_wr |=> ##1 jitter_period_select == $past(pwdata[1], 2))
        else $error("period output does not follow config");
endmodule : lej_regs_assertions

bind lej_regs lej_regs_assertions u_lej_chk (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .line_evt(line_evt), .irq(irq),
    .jitter_filter_band(jitter_filter_band), .jitter_period_select(jitter_period_select));
`default_nettype wire

// ### bench/tb.sv
// self-checking bench for the line error and jitter register bank
`default_nettype none
module tb
    import lej_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic            pclk, presetn, pce, psel, penable, pwrite;
    logic [15:0]     paddr;
    logic [31:0]     pwdata, prdata, got;
    logic            pready, pslverr, band, per_sel, irq, err;
    lej_evt_t [15:0] line_evt;
    lej_peak_t       peak_in;
    int              fail_count, n_compared, ch;

    always #50 pclk = ~pclk;

    lej_regs #(.PERIOD_CYC(20)) dut (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .line_evt(line_evt), .peak_in(peak_in),
        .jitter_filter_band(band), .jitter_period_select(per_sel), .irq(irq));

    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        if (fail_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    // setup cycle, then access until pready is seen high at an edge
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        got = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rd(input logic [15:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, e, got);
    endtask : rd

    function automatic logic [15:0] ba(input int c, input logic [10:0] r);
        return 16'((c - 1) * 256) + {3'h0, r, 2'h0};
    endfunction : ba

    initial begin
        #9000000;
        fail_count++;
        close_out();
    end

    initial begin
        pclk     = 1'b0;
        presetn  = 1'b0;
        pce      = 1'b1;
        psel     = 1'b0;
        penable  = 1'b0;
        pwrite   = 1'b0;
        paddr    = 16'h0;
        pwdata   = 32'h0;
        line_evt = '0;
        peak_in  = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(ba(1, 11'h022), 32'h0, "status reset");
        rd(16'h1F8C, 32'h0, "ch0 count low reset");
        rd(16'h1F90, 32'h0, "ch0 count high reset");
        rd(16'h1F94, 32'h0, "config reset");
        for (int b = 1; b < 6; b++) begin
            for (int j = 0; j < 2; j++) begin
                ch = j ? 15 : b;
                line_evt[ch] <= lej_evt_t'(6'h01 << b);
                @(posedge pclk);
                line_evt[ch] <= '0;
                @(posedge pclk);
                chk("irq set", 32'h1, {31'h0, irq});
                rd(ba(ch, 11'h022), 32'h1 << b, "status flag");
                apb(1'b1, ba(ch, 11'h022), 32'h1 << b);
                chk("irq clear", 32'h0, {31'h0, irq});
                rd(ba(ch, 11'h022), 32'h0, "status cleared");
            end
        end
        // frozen clock enable: an event must not set its flag
        pce <= 1'b0;
        line_evt[3].lbpv <= 1'b1;
        @(posedge pclk);
        pce <= 1'b1;
        line_evt[3] <= '0;
        @(posedge pclk);
        chk("irq frozen", 32'h0, {31'h0, irq});
        apb(1'b1, 16'h1FC0, 32'h1);
        line_evt[1].cnt_err <= 1'b1;
        repeat (5) @(posedge pclk);
        line_evt[1].cnt_err <= 1'b0;
        rd(ba(1, 11'h023), 32'h0, "count before update");
        apb(1'b1, 16'h1FC0, 32'h3);
        rd(ba(1, 11'h023), 32'h5, "count low");
        rd(ba(1, 11'h024), 32'h0, "count high");
        // one pulse per cycle: wraps past 0xFFFF and leaves 3
        line_evt[1].cnt_err <= 1'b1;
        repeat (65539) @(posedge pclk);
        line_evt[1].cnt_err <= 1'b0;
        apb(1'b1, 16'h1FC0, 32'h3);
        rd(ba(1, 11'h023), 32'h3, "count after wrap");
        rd(ba(1, 11'h022), 32'h1, "overflow flag");
        chk("irq overflow", 32'h1, {31'h0, irq});
        apb(1'b1, ba(1, 11'h023), 32'hFF);
        rd(ba(1, 11'h023), 32'h3, "count read only");
        rd(16'h0004, 32'h0, "unmapped read");
        chk("unmapped error", 32'h1, {31'h0, err});
        peak_in <= {12'hABC, 12'h123};
        apb(1'b1, 16'h1F94, 32'h4);
        rd(16'h1F98, 32'hBC, "pos low");
        rd(16'h1F9C, 32'hA, "pos high");
        rd(16'h1FA0, 32'h23, "neg low");
        rd(16'h1FA4, 32'h1, "neg high");
        apb(1'b1, 16'h1F94, 32'h0);
        peak_in <= {12'h456, 12'h789};
        repeat (25) @(posedge pclk);
        rd(16'h1F98, 32'hBC, "pos held manual");
        apb(1'b1, 16'h1F94, 32'h3);
        repeat (25) @(posedge pclk);
        rd(16'h1F98, 32'h56, "pos auto");
        rd(16'h1FA4, 32'h7, "neg high auto");
        chk("band out", 32'h1, {31'h0, band});
        rd(16'h1F94, 32'h3, "config readback");
        close_out();
    end
endmodule : tb
`default_nettype wire
